// file: logic/mps_pkg.sv
// Constants and types for the marked-paper command sequencer.
// Assumes one 125 MHz clock and a feed motor of 0.125 mm per step.
package mps_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STEP_UM = 125;
  localparam int MARK_LEAD_UM = 2000;
  localparam int MARK_BLANK_UM = 20000;
  localparam int PRINT_OFF_UM = 17600;
  localparam int CUT_OFF_UM = 33600;
  localparam int STEP_TIME_NS = 1000000;
  localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [7:0] MARK_LEAD_STEPS =
    8'((MARK_LEAD_UM + STEP_UM - 1) / STEP_UM);
  localparam logic [7:0] MARK_BLANK_STEPS =
    8'((MARK_BLANK_UM + STEP_UM - 1) / STEP_UM);
  localparam logic signed [15:0] PRINT_OFF_RST =
    16'((PRINT_OFF_UM + STEP_UM / 2) / STEP_UM);
  localparam logic signed [15:0] CUT_OFF_RST =
    16'((CUT_OFF_UM + STEP_UM / 2) / STEP_UM);
  localparam logic [7:0] REV_LIMIT = 8'h76;
  localparam logic [4:0] BASE_FONT_A = 5'h12;
  localparam logic [4:0] BASE_FONT_B = 5'h0E;
  localparam logic [7:0] CODE_LF = 8'h0A;
  localparam logic [7:0] CODE_CR = 8'h0D;
  localparam logic [7:0] CODE_FF = 8'h0C;
  localparam logic [7:0] CODE_GS = 8'h1D;
  localparam logic [7:0] CODE_PAREN = 8'h28;
  localparam logic [7:0] CODE_F = 8'h46;
  localparam logic [7:0] CODE_V = 8'h56;
  localparam logic [1:0] OFFSET_LAST_ARG = 2'h3;
  localparam int FIFO_AW = 4;

  typedef struct packed {
    logic mark_en;
    logic auto_lf;
  } mps_cfg_t;

  typedef struct packed {
    logic step_fwd;
    logic step_rev;
    logic cut;
  } mps_motor_t;

  typedef enum logic [1:0] {K_FEED, K_CUT_MARK, K_CUT_PLAIN} mps_kind_t;
  typedef enum logic [2:0] {P_OP, P_GS, P_PAREN, P_ARGS, P_CUT_M, P_CUT_N}
    mps_pstate_t;
  typedef enum logic [2:0] {S_IDLE, S_SEARCH, S_TO_CUT, S_CUT, S_TO_PRINT,
    S_ERROR} mps_seq_t;
endpackage

// file: logic/mps_sequencer.sv
// Marked-paper command sequencer: receive buffer, byte parser, mark
// search, offset positioning, cutter and line codes.
// Assumes cut_done_in and rx_* come from logic on ref_clk_in.
//
// Functional notes
// - In mark mode the paper-end lamp lights whenever the sensor sees dark.
// - A mark registers once its edge has moved 2 mm past the sensor.
// - After a mark, further marks are ignored for 2 cm of paper.
// - Mark positioning works only if enabled by strap at start-up.
// - Zero offset means mark at head for print, at cutter for cut.
// - Offsets default to 17,6 mm for print and 33,6 mm for cut.
// - Offset command stores signed cut and print distances.
// - Feed command searches the mark then moves to print position.
// - Mark cut searches, moves to cut position, cuts, then to print.
// - Reverse feed only in mark commands, at most 118 steps total.
// - Feed button in mark mode starts the mark cut sequence.
// - CR acts as LF with auto line feed, else is discarded.
// - Auto line feed is fixed by strap at start-up.
// - Processing CR with auto line feed returns print start to line beginning.
// - Ignored commands consume all their bytes and change nothing.
// - Host bytes are buffered unmodified and taken in arrival order.
// - Baseline is 18 dots for large font, 14 for small font.
// - A missing mark raises an error held until reset.
`timescale 1ns/1ps
module mps_sequencer #(
  parameter int STEP_CYCLES_P = mps_pkg::STEP_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic paper_sensor_in,
  input wire logic paper_feed_button_in,
  input wire logic mark_enable_strap_in,
  input wire logic auto_lf_strap_in,
  input wire logic [15:0] max_search_steps_in,
  input wire logic small_font_in,
  input wire logic cut_done_in,
  output mps_pkg::mps_motor_t motor_out,
  output logic line_feed_out,
  output logic line_start_out,
  output logic [4:0] baseline_out,
  output logic paper_end_indicator_out,
  output logic mark_error_out,
  output logic busy_out
);
  import mps_pkg::*;

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic sens_s;
  logic btn_s;
  logic btn_prev_q;
  logic [1:0] init_q;
  logic cfg_done_q;
  mps_cfg_t cfg_q;
  logic [7:0] mem_q [0:(1 << FIFO_AW) - 1];
  logic [FIFO_AW:0] wr_q;
  logic [FIFO_AW:0] rd_q;
  logic empty;
  logic full;
  logic pop;
  logic [7:0] byte_c;
  mps_pstate_t p_q;
  logic [1:0] arg_q;
  logic [23:0] argbuf_q;
  logic start_q;
  mps_kind_t kind_q;
  mps_seq_t seq_q;
  logic mark_flow_q;
  logic do_cut_q;
  logic signed [15:0] print_off_q;
  logic signed [15:0] cut_off_q;
  logic signed [15:0] pos_q;
  logic signed [15:0] target;
  logic [7:0] rev_q;
  logic [7:0] blank_q;
  logic [7:0] lead_q;
  logic lead_arm_q;
  logic [15:0] search_q;
  logic [31:0] tmr_q;
  logic positioning;
  logic want_fwd;
  logic want_rev;
  logic at_target;
  logic tick_fwd;
  logic tick_rev;
  logic mark_hit;
  logic search_fail;
  logic cut_go;
  logic btn_start;

  // Pin synchronisers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      btn_prev_q <= 1'b0;
    end else begin
      sync1_q <= {paper_sensor_in, paper_feed_button_in,
                  mark_enable_strap_in, auto_lf_strap_in};
      sync2_q <= sync1_q;
      btn_prev_q <= sync2_q[2];
    end
  end
  assign sens_s = sync2_q[3];
  assign btn_s = sync2_q[2];

  // Strap capture once the synchronisers hold settled values
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      init_q <= 2'h0;
      cfg_done_q <= 1'b0;
      cfg_q <= '0;
    end else if (!cfg_done_q) begin
      init_q <= init_q + 2'h1;
      if (init_q == 2'h2) begin
        cfg_done_q <= 1'b1;
        cfg_q <= {sync2_q[1], sync2_q[0]};
      end
    end
  end

  // Receive buffer
  assign empty = (wr_q == rd_q);
  assign full = (wr_q[FIFO_AW] != rd_q[FIFO_AW]) &&
                (wr_q[FIFO_AW-1:0] == rd_q[FIFO_AW-1:0]);
  assign rx_ready_out = !full;
  assign byte_c = mem_q[rd_q[FIFO_AW-1:0]];
  assign btn_start = btn_s && !btn_prev_q && cfg_q.mark_en && cfg_done_q &&
                     seq_q == S_IDLE && !start_q;
  assign pop = !empty && cfg_done_q && seq_q == S_IDLE && !start_q &&
               !btn_start;

  always_ff @(posedge ref_clk_in) begin
    if (rx_valid_in && !full) begin
      mem_q[wr_q[FIFO_AW-1:0]] <= rx_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (rx_valid_in && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  // Command parser
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      p_q <= P_OP;
      arg_q <= 2'h0;
      argbuf_q <= 24'h000000;
      start_q <= 1'b0;
      kind_q <= K_FEED;
      line_feed_out <= 1'b0;
      line_start_out <= 1'b0;
      print_off_q <= PRINT_OFF_RST;
      cut_off_q <= CUT_OFF_RST;
    end else begin
      start_q <= 1'b0;
      line_feed_out <= 1'b0;
      line_start_out <= 1'b0;
      if (btn_start) begin
        start_q <= 1'b1;
        kind_q <= K_CUT_MARK;
      end else if (pop) begin
        case (p_q)
          P_OP: begin
            if (byte_c == CODE_LF ||
                (byte_c == CODE_CR && cfg_q.auto_lf)) begin
              line_feed_out <= 1'b1;
              line_start_out <= 1'b1;
            end else if (byte_c == CODE_GS) begin
              p_q <= P_GS;
            end
          end
          P_GS: begin
            p_q <= P_OP;
            if (byte_c == CODE_PAREN) begin
              p_q <= P_PAREN;
            end else if (byte_c == CODE_V) begin
              p_q <= P_CUT_M;
            end else if (byte_c == CODE_FF && cfg_q.mark_en) begin
              start_q <= 1'b1;
              kind_q <= K_FEED;
            end
          end
          P_PAREN: begin
            p_q <= (byte_c == CODE_F) ? P_ARGS : P_OP;
            arg_q <= 2'h0;
          end
          P_ARGS: begin
            argbuf_q <= {byte_c, argbuf_q[23:8]};
            arg_q <= arg_q + 2'h1;
            if (arg_q == OFFSET_LAST_ARG) begin
              p_q <= P_OP;
              if (cfg_q.mark_en) begin
                cut_off_q <= {argbuf_q[15:8], argbuf_q[7:0]};
                print_off_q <= {byte_c, argbuf_q[23:16]};
              end
            end
          end
          P_CUT_M: begin
            p_q <= P_CUT_N;
          end
          P_CUT_N: begin
            p_q <= P_OP;
            start_q <= 1'b1;
            kind_q <= cfg_q.mark_en ? K_CUT_MARK : K_CUT_PLAIN;
          end
          default: begin
            p_q <= P_OP;
          end
        endcase
      end
    end
  end

  // Positioning arithmetic
  assign positioning = (seq_q == S_TO_CUT) || (seq_q == S_TO_PRINT);
  assign target = (seq_q == S_TO_CUT) ? cut_off_q : print_off_q;
  assign want_fwd = (seq_q == S_SEARCH) || (positioning && pos_q < target);
  assign want_rev = positioning && pos_q > target &&
                    rev_q < REV_LIMIT;
  assign at_target = positioning && !want_fwd && !want_rev;
  assign tick_fwd = want_fwd && tmr_q == 32'h0;
  assign tick_rev = want_rev && tmr_q == 32'h0;
  assign mark_hit = (seq_q == S_SEARCH) && tick_fwd && lead_arm_q &&
                    lead_q == MARK_LEAD_STEPS - 8'h01;
  assign search_fail = (seq_q == S_SEARCH) && !lead_arm_q &&
                       search_q >= max_search_steps_in;
  assign cut_go = ((seq_q == S_TO_CUT) && at_target) ||
                  ((seq_q == S_IDLE) && start_q && kind_q == K_CUT_PLAIN);

  // Step pacing
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tmr_q <= 32'h0;
    end else if (!(want_fwd || want_rev) || search_fail) begin
      tmr_q <= 32'h0;
    end else if (tmr_q == 32'h0) begin
      tmr_q <= 32'(STEP_CYCLES_P - 1);
    end else begin
      tmr_q <= tmr_q - 32'h1;
    end
  end

  // Paper position, reverse budget, mark detection
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_q <= 16'h0000;
      rev_q <= 8'h00;
      blank_q <= 8'h00;
      lead_q <= 8'h00;
      lead_arm_q <= 1'b0;
      search_q <= 16'h0000;
    end else if (seq_q == S_IDLE) begin
      rev_q <= 8'h00;
      search_q <= 16'h0000;
      lead_arm_q <= 1'b0;
      lead_q <= 8'h00;
    end else begin
      if (tick_fwd) begin
        pos_q <= pos_q + 16'sh0001;
      end
      if (tick_rev) begin
        pos_q <= pos_q - 16'sh0001;
        rev_q <= rev_q + 8'h01;
      end
      if ((tick_fwd || tick_rev) && blank_q != 8'h00) begin
        blank_q <= blank_q - 8'h01;
      end
      if (seq_q == S_SEARCH) begin
        if (tick_fwd) begin
          search_q <= search_q + 16'h0001;
        end
        if (lead_arm_q && tick_fwd) begin
          lead_q <= lead_q + 8'h01;
        end
        if (sens_s && blank_q == 8'h00 && !lead_arm_q) begin
          lead_arm_q <= 1'b1;
          lead_q <= 8'h00;
        end
      end
      if (mark_hit) begin
        pos_q <= 16'h0000;
        blank_q <= MARK_BLANK_STEPS;
        lead_arm_q <= 1'b0;
      end
    end
  end

  // Sequence control
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      seq_q <= S_IDLE;
      mark_flow_q <= 1'b0;
      do_cut_q <= 1'b0;
    end else begin
      case (seq_q)
        S_IDLE: begin
          if (start_q) begin
            mark_flow_q <= (kind_q != K_CUT_PLAIN);
            do_cut_q <= (kind_q != K_FEED);
            seq_q <= (kind_q == K_CUT_PLAIN) ? S_CUT : S_SEARCH;
          end
        end
        S_SEARCH: begin
          if (search_fail) begin
            seq_q <= S_ERROR;
          end else if (mark_hit) begin
            seq_q <= do_cut_q ? S_TO_CUT : S_TO_PRINT;
          end
        end
        S_TO_CUT: begin
          if (at_target) begin
            seq_q <= S_CUT;
          end
        end
        S_CUT: begin
          if (cut_done_in) begin
            seq_q <= mark_flow_q ? S_TO_PRINT : S_IDLE;
          end
        end
        S_TO_PRINT: begin
          if (at_target) begin
            seq_q <= S_IDLE;
          end
        end
        S_ERROR: begin
          seq_q <= S_ERROR;
        end
        default: begin
          seq_q <= S_IDLE;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      motor_out <= '0;
      paper_end_indicator_out <= 1'b0;
      mark_error_out <= 1'b0;
      busy_out <= 1'b0;
      baseline_out <= BASE_FONT_A;
    end else begin
      motor_out.step_fwd <= tick_fwd;
      motor_out.step_rev <= tick_rev;
      motor_out.cut <= cut_go;
      paper_end_indicator_out <= sens_s;
      mark_error_out <= mark_error_out || search_fail;
      busy_out <= (seq_q != S_IDLE) || start_q;
      baseline_out <= small_font_in ? BASE_FONT_B : BASE_FONT_A;
    end
  end

  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  pe_follow_a: assert property (
    cfg_q.mark_en && sens_s |=> paper_end_indicator_out)
    else $error("paper-end lamp not lit on dark mark");
  mark_lead_a: assert property (
    mark_hit |=> pos_q == 16'h0000 && blank_q == MARK_BLANK_STEPS)
    else $error("mark registration did not reset position");
  blank_hold_a: assert property (
    blank_q != 8'h00 && !lead_arm_q |=> !lead_arm_q)
    else $error("mark detected inside blanking distance");
  mark_off_a: assert property (
    cfg_done_q && !cfg_q.mark_en |-> seq_q == S_IDLE || seq_q == S_CUT)
    else $error("mark sequence ran with mark mode disabled");
  rev_limit_a: assert property (
    motor_out.step_rev |-> $past(positioning) && rev_q <= REV_LIMIT)
    else $error("reverse step outside positioning or over limit");
  err_sticky_a: assert property (
    mark_error_out |=> mark_error_out && seq_q == S_ERROR)
    else $error("mark error cleared");
  search_stop_a: assert property (
    search_fail |=> seq_q == S_ERROR ##1 !motor_out.step_fwd[*3])
    else $error("feed continued after failed search");
  busy_stall_a: assert property (
    seq_q != S_IDLE |-> !pop)
    else $error("byte taken while sequence busy");
  cr_drop_a: assert property (
    pop && p_q == P_OP && byte_c == CODE_CR && !cfg_q.auto_lf
    |=> !line_feed_out && !line_start_out)
    else $error("CR acted with auto line feed off");
  baseline_a: assert property (
    small_font_in ##1 small_font_in |-> baseline_out == BASE_FONT_B)
    else $error("wrong baseline for small font");
endmodule

// file: bench/mps_host_model.sv
// Far-side model: host byte queue, marked paper roll and cutter.
// Assumes the sequencer on one clock; outputs move 1 ns after the edge.
`timescale 1ns/1ps
module mps_host_model (
  input wire logic clk_in,
  input wire logic rx_ready_in,
  input wire mps_pkg::mps_motor_t motor_in,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic paper_sensor_out,
  output logic cut_done_out
);
  import mps_pkg::*;
  logic [7:0] q[$];
  int pos = 0;
  int fwd = 0;
  int rev = 0;
  int cuts = 0;
  int cd = 0;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    paper_sensor_out = 1'b0;
    cut_done_out = 1'b0;
  end
  task automatic put(input logic [7:0] b);
    q.push_back(b);
  endtask
  task automatic clr();
    fwd = 0;
    rev = 0;
    cuts = 0;
  endtask
  // Marks 8 steps long every 400 steps, dark from step 20 on
  always @(posedge clk_in) begin
    if (rx_valid_out && rx_ready_in) void'(q.pop_front());
    if (motor_in.step_fwd) begin
      pos++;
      fwd++;
    end
    if (motor_in.step_rev) begin
      pos--;
      rev++;
    end
    if (motor_in.cut) begin
      cuts++;
      cd = 6;
    end else if (cd > 0) cd--;
    #1;
    rx_valid_out = q.size() > 0;
    rx_data_out = rx_valid_out ? q[0] : ~rx_data_out;
    paper_sensor_out = (pos % 400) >= 20 && (pos % 400) < 28;
    cut_done_out = cd == 1;
  end
endmodule

// file: bench/test_mps_sequencer.sv
// Self-checking bench for the marked-paper command sequencer.
// Assumes the host model on the far side and an 8-cycle step.
`timescale 1ns/1ps
module test_mps_sequencer;
  import mps_pkg::*;
  typedef logic [7:0] mps_bytes_t[$];
  logic ref_clk_in, rstn_in, button, mark_strap, alf_strap, small_font;
  logic [15:0] max_steps;
  logic [7:0] rx_data;
  logic rx_valid, rx_ready, sensor, cut_done, lf, ls, pe, merr, busy;
  logic [4:0] baseline;
  mps_motor_t motor;
  int bad_count = 0;
  int cmp_count = 0;
  int nlf = 0;
  int nls = 0;
  int pe_bad = 0;
  int f;
  logic pe_on = 1'b0;
  logic [2:0] hist = 3'h0;

  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  mps_sequencer #(.STEP_CYCLES_P(8)) i_mps_sequencer (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
    .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_ready_out(rx_ready), .paper_sensor_in(sensor),
    .paper_feed_button_in(button), .mark_enable_strap_in(mark_strap),
    .auto_lf_strap_in(alf_strap), .max_search_steps_in(max_steps),
    .small_font_in(small_font), .cut_done_in(cut_done),
    .motor_out(motor), .line_feed_out(lf), .line_start_out(ls),
    .baseline_out(baseline), .paper_end_indicator_out(pe),
    .mark_error_out(merr), .busy_out(busy));

  mps_host_model i_mps_host_model (
    .clk_in(ref_clk_in), .rx_ready_in(rx_ready), .motor_in(motor),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .paper_sensor_out(sensor), .cut_done_out(cut_done));

  // Line pulses counted mid-cycle, where they have settled
  always @(negedge ref_clk_in) begin
    if (lf === 1'b1) nlf++;
    if (ls === 1'b1) nls++;
  end

  // Lamp must follow the sensor pin three cycles late
  always @(negedge ref_clk_in) begin
    if (pe_on && pe !== hist[2]) pe_bad++;
    hist = {hist[1:0], sensor};
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    while (i_mps_host_model.q.size() > 0 && n < 1000) begin
      @(posedge ref_clk_in);
      n++;
    end
    repeat (4) @(posedge ref_clk_in);
    while (busy !== 1'b0 && n < 30000) begin
      @(posedge ref_clk_in);
      n++;
    end
    #1;
    chk(busy, 16'h0000);
  endtask

  task automatic send(input mps_bytes_t b);
    i_mps_host_model.clr();
    foreach (b[i]) i_mps_host_model.put(b[i]);
    settle();
  endtask

  task automatic press();
    button = 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1 button = 1'b0;
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    rstn_in = 1'b0;
    button = 1'b0;
    mark_strap = 1'b1;
    alf_strap = 1'b1;
    small_font = 1'b0;
    max_steps = 16'h0FFF;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk(baseline, 16'h0012);
    chk({rx_ready, busy, merr, motor}, 16'h0020);
    repeat (2) @(posedge ref_clk_in);
    #1 rstn_in = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1 pe_on = 1'b1;
    alf_strap = 1'b0;
    send('{CODE_CR});
    chk(nlf, 16'h0001);
    chk(nls, 16'h0001);
    send('{CODE_LF});
    chk(nlf, 16'h0002);
    small_font = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1 chk(baseline, 16'h000E);
    send('{CODE_GS, CODE_FF});
    f = 20 + MARK_LEAD_STEPS + PRINT_OFF_RST;
    chk(i_mps_host_model.fwd, f);
    chk(i_mps_host_model.rev, 16'h0000);
    send('{CODE_GS, CODE_V, 8'h00, 8'h00});
    chk(i_mps_host_model.fwd, 420 + MARK_LEAD_STEPS + CUT_OFF_RST - f);
    chk(i_mps_host_model.rev, REV_LIMIT);
    chk(i_mps_host_model.cuts, 16'h0001);
    send('{CODE_GS, CODE_PAREN, CODE_F, 8'h0A, 8'h00, 8'hFB, 8'hFF});
    chk(i_mps_host_model.fwd, 16'h0000);
    chk(nlf, 16'h0002);
    send('{CODE_GS, CODE_FF});
    chk(i_mps_host_model.fwd, 836 - 587);
    chk(i_mps_host_model.rev, 16'h0005);
    i_mps_host_model.clr();
    press();
    settle();
    chk(i_mps_host_model.fwd, 1246 - 831);
    chk(i_mps_host_model.rev, 16'h000F);
    chk(i_mps_host_model.cuts, 16'h0001);
    max_steps = 16'h0032;
    i_mps_host_model.clr();
    i_mps_host_model.put(CODE_GS);
    i_mps_host_model.put(CODE_FF);
    for (int n = 0; n < 3000 && merr !== 1'b1; n++) @(posedge ref_clk_in);
    #1;
    chk(merr, 16'h0001);
    f = i_mps_host_model.fwd;
    repeat (200) @(posedge ref_clk_in);
    #1 chk(i_mps_host_model.fwd, f);
    chk(f <= 50, 16'h0001);
    chk(merr, 16'h0001);
    pe_on = 1'b0;
    chk(pe_bad, 16'h0000);
    rstn_in = 1'b0;
    mark_strap = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    #1 rstn_in = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #1 chk(merr, 16'h0000);
    send('{CODE_CR});
    chk(nlf, 16'h0002);
    chk(nls, 16'h0002);
    send('{CODE_GS, CODE_FF, CODE_GS, CODE_PAREN, CODE_F, 8'h0A, 8'h00,
      8'h0A, 8'h00, CODE_GS, 8'h41, CODE_LF});
    chk(i_mps_host_model.fwd, 16'h0000);
    chk(nlf, 16'h0003);
    send('{CODE_GS, CODE_V, 8'h00, 8'h00});
    chk(i_mps_host_model.cuts, 16'h0001);
    chk(i_mps_host_model.fwd + i_mps_host_model.rev, 16'h0000);
    press();
    repeat (20) @(posedge ref_clk_in);
    #1 chk(busy, 16'h0000);
    results();
  end
endmodule
